// ### core/hdfs_line_if.sv
// carrier between register file, pin driver and line sensor
// assumes all three sit on ref_clk
`timescale 1ns/1ns
interface hdfs_line_if;
    logic [13:0] drive_code;
    logic [6:0]  force_dp;
    logic [6:0]  force_dm;
    logic [6:0]  low_speed;
    logic [6:0]  se0;
    logic [6:0]  diff;

    modport ctrl (output drive_code, output force_dp, output force_dm, output low_speed,
                  input se0, input diff);
    modport drv  (input drive_code, input force_dp, input force_dm, input low_speed);
    modport sns  (output se0, output diff);
endinterface

// ### core/hdfs_line_sense.sv
// line sensor: se0 status and held differential data of every port
// assumes dp_in/dm_in are raw pin levels from outside the clock domain
`timescale 1ns/1ns
`include "hdfs_params.svh"
module hdfs_line_sense (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        usb_bus_reset,
    // pins
    input  wire logic [6:0]  dp_in,
    input  wire logic [6:0]  dm_in,
    // results
    hdfs_line_if.sns         line
);
    logic [6:0] dp_meta_reg;
    logic [6:0] dm_meta_reg;
    logic [6:0] dp_sync_reg;
    logic [6:0] dm_sync_reg;
    logic [6:0] se0_reg;
    logic [6:0] se0_next;
    logic [6:0] diff_reg;
    logic [6:0] diff_next;
    logic [1:0] fill_reg;
    logic [1:0] fill_next;

    always_comb begin
        se0_next  = se0_reg;
        diff_next = diff_reg;
        fill_next = {fill_reg[0], 1'b1};
        if (usb_bus_reset) begin
            se0_next  = `HDFS_RST_SENSE;
            diff_next = `HDFS_RST_SENSE;
        end else if (fill_reg[1]) begin
            // wait for real pin levels in the synchronisers, else a false se0 after reset
            for (int p = 0; p < `HDFS_NPORTS; p++) begin
                se0_next[p] = ~dp_sync_reg[p] & ~dm_sync_reg[p];
                // se0 and se1 keep the last differential value
                if (dp_sync_reg[p] != dm_sync_reg[p]) begin
                    diff_next[p] = dp_sync_reg[p];
                end
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dp_meta_reg <= `HDFS_RST_SENSE;
            dm_meta_reg <= `HDFS_RST_SENSE;
            dp_sync_reg <= `HDFS_RST_SENSE;
            dm_sync_reg <= `HDFS_RST_SENSE;
            se0_reg     <= `HDFS_RST_SENSE;
            diff_reg    <= `HDFS_RST_SENSE;
            fill_reg    <= 2'b00;
        end else begin
            dp_meta_reg <= dp_in;
            dm_meta_reg <= dm_in;
            dp_sync_reg <= dp_meta_reg;
            dm_sync_reg <= dm_meta_reg;
            se0_reg     <= se0_next;
            diff_reg    <= diff_next;
            fill_reg    <= fill_next;
        end
    end

    assign line.se0  = se0_reg;
    assign line.diff = diff_reg;
endmodule

// ### core/hdfs_params.svh
// constants of the downstream port force and sense block
// assumes byte-addressed avalon-mm, one 32-bit word per register
`ifndef HDFS_PARAMS_SVH
`define HDFS_PARAMS_SVH

`define HDFS_NPORTS        7
`define HDFS_NDRIVE        4
`define HDFS_ADDR_W        10
`define HDFS_DATA_W        32

// register indices; byte address is four times the index
`define HDFS_IDX_ENABLE    8'h49
`define HDFS_IDX_SPEED     8'h4a
`define HDFS_IDX_DRIVE     8'h4b
`define HDFS_IDX_SE0       8'h4f
`define HDFS_IDX_DATA      8'h50
`define HDFS_IDX_FLOW14    8'h51
`define HDFS_IDX_FLOW57    8'h52

// reset values
`define HDFS_RST_ENABLE    7'h00
`define HDFS_RST_SPEED     7'h00
`define HDFS_RST_DRIVE     8'h00
`define HDFS_RST_FLOW14    8'h00
`define HDFS_RST_FLOW57    6'h00
`define HDFS_RST_SENSE     7'h00

`endif

// ### core/hdfs_pin_drive.sv
// pin driver: merges drive codes and force-low bits into pin controls
// assumes the pad applies edge shaping when the shaped output is high
`timescale 1ns/1ns
`include "hdfs_params.svh"
module hdfs_pin_drive (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // controls
    hdfs_line_if.drv         line,
    // pins
    output logic [6:0]       dp_out,
    output logic [6:0]       dm_out,
    output logic [6:0]       dp_oe_n,
    output logic [6:0]       dm_oe_n,
    output logic [6:0]       dp_shaped,
    output logic [6:0]       dm_shaped,
    output logic [6:0]       shape_low_speed
);
    logic [6:0] dp_out_next;
    logic [6:0] dm_out_next;
    logic [6:0] dp_oe_n_next;
    logic [6:0] dm_oe_n_next;
    logic [6:0] dp_shaped_next;
    logic [6:0] dm_shaped_next;
    hdfs_pkg::hdfs_drive_t code;

    always_comb begin
        code           = hdfs_pkg::HDFS_DRV_NONE;
        dp_out_next    = 7'h00;
        dm_out_next    = 7'h00;
        dp_oe_n_next   = 7'h7f;
        dm_oe_n_next   = 7'h7f;
        dp_shaped_next = 7'h00;
        dm_shaped_next = 7'h00;
        for (int p = 0; p < `HDFS_NPORTS; p++) begin
            code = hdfs_pkg::hdfs_drive_t'(line.drive_code[2*p +: 2]);
            case (code)
                hdfs_pkg::HDFS_DRV_DIFF1: begin
                    dp_out_next[p]  = 1'b1;
                    dm_out_next[p]  = 1'b0;
                    dp_oe_n_next[p] = 1'b0;
                    dm_oe_n_next[p] = 1'b0;
                end
                hdfs_pkg::HDFS_DRV_DIFF0: begin
                    dp_out_next[p]  = 1'b0;
                    dm_out_next[p]  = 1'b1;
                    dp_oe_n_next[p] = 1'b0;
                    dm_oe_n_next[p] = 1'b0;
                end
                hdfs_pkg::HDFS_DRV_SE0: begin
                    dp_out_next[p]  = 1'b0;
                    dm_out_next[p]  = 1'b0;
                    dp_oe_n_next[p] = 1'b0;
                    dm_oe_n_next[p] = 1'b0;
                end
                default: begin
                    dp_oe_n_next[p] = 1'b1;
                    dm_oe_n_next[p] = 1'b1;
                end
            endcase
            dp_shaped_next[p] = ~dp_oe_n_next[p];
            dm_shaped_next[p] = ~dm_oe_n_next[p];
            // force-low overrides the drive code on its own pin only
            if (line.force_dp[p]) begin
                dp_out_next[p]    = 1'b0;
                dp_oe_n_next[p]   = 1'b0;
                dp_shaped_next[p] = 1'b0;
            end
            if (line.force_dm[p]) begin
                dm_out_next[p]    = 1'b0;
                dm_oe_n_next[p]   = 1'b0;
                dm_shaped_next[p] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            dp_out          <= 7'h00;
            dm_out          <= 7'h00;
            dp_oe_n         <= 7'h7f;
            dm_oe_n         <= 7'h7f;
            dp_shaped       <= 7'h00;
            dm_shaped       <= 7'h00;
            shape_low_speed <= 7'h00;
        end else begin
            dp_out          <= dp_out_next;
            dm_out          <= dm_out_next;
            dp_oe_n         <= dp_oe_n_next;
            dm_oe_n         <= dm_oe_n_next;
            dp_shaped       <= dp_shaped_next;
            dm_shaped       <= dm_shaped_next;
            shape_low_speed <= line.low_speed;
        end
    end
endmodule

// ### core/hdfs_pkg.sv
// types of the downstream port force and sense block
// assumes hdfs_params.svh supplies the numeric constants
package hdfs_pkg;

    // two-bit drive control code of one downstream port
    typedef enum logic [1:0] {
        HDFS_DRV_NONE  = 2'b00,
        HDFS_DRV_DIFF1 = 2'b01,
        HDFS_DRV_DIFF0 = 2'b10,
        HDFS_DRV_SE0   = 2'b11
    } hdfs_drive_t;

endpackage

// ### core/hdfs_top.sv
// downstream port force and sense block of a hub repeater, top level
// assumes an avalon-mm master on ref_clk and raw d+/d- pins of 7 ports
//
// Contract
// - drive code 00 none, 01 d+ high d- low, 10 d+ low d- high, 11 se0
// - drive register: port1 bits 1:0 up to port4 bits 7:6, high bit is bit 1
// - drive register clears on chip reset; bus reset leaves it alone
// - drive-code forcing uses edge shaping chosen by port speed
// - force-low bit drives its pin low; d+ upper, d- lower bit of a pair
// - force-low pins are driven without edge shaping
// - force-low bits keep holding pins low during suspend
// - data register shows differential state only, independent of speed
// - data bit 1 when d+ above d-, 0 when d- above d+; ports 1-7 bits 0-6
// - during se0 the data bit keeps the last differential value
// - se0 status bit x-1 is 1 while port x sits in se0
// - se0 status and data clear on chip reset and on bus reset
// - bit 7 of se0 status and data always reads zero
// - speed bit 1 means low speed, 0 full speed; selects shaping
// - enable bit 1 lets the repeater pass traffic, 0 disables the port
`timescale 1ns/1ns
`include "hdfs_params.svh"
module hdfs_top (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    input  wire logic        usb_bus_reset,
    // avalon-mm slave
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // downstream pins
    input  wire logic [6:0]  dp_in,
    input  wire logic [6:0]  dm_in,
    output logic [6:0]       dp_out,
    output logic [6:0]       dm_out,
    output logic [6:0]       dp_oe_n,
    output logic [6:0]       dm_oe_n,
    output logic [6:0]       dp_shaped,
    output logic [6:0]       dm_shaped,
    output logic [6:0]       shape_low_speed,
    // repeater controls
    output logic [6:0]       port_enable,
    output logic [6:0]       port_low_speed
);
    hdfs_line_if line ();

    logic [6:0]  enable_reg;
    logic [6:0]  enable_next;
    logic [6:0]  speed_reg;
    logic [6:0]  speed_next;
    logic [7:0]  drive_reg;
    logic [7:0]  drive_next;
    logic [7:0]  flow14_reg;
    logic [7:0]  flow14_next;
    logic [5:0]  flow57_reg;
    logic [5:0]  flow57_next;
    logic [31:0] readdata_reg;
    logic [31:0] readdata_next;
    logic        waitreq_reg;
    logic        waitreq_next;
    logic        wr_fire;
    logic        rd_load;
    logic        word_ok;
    logic [7:0]  idx;
    logic [7:0]  wbyte;

    assign idx     = avs_address[9:2];
    assign word_ok = (avs_address[1:0] == 2'b00);
    assign wbyte   = avs_writedata[7:0];

    // one wait cycle per access; write lands where waitrequest is seen low
    assign wr_fire = avs_write & ~waitreq_reg & avs_byteenable[0] & word_ok;
    assign rd_load = avs_read & waitreq_reg;

    always_comb begin
        waitreq_next = ~((avs_read | avs_write) & waitreq_reg);
    end

    // register writes
    always_comb begin
        enable_next = enable_reg;
        speed_next  = speed_reg;
        drive_next  = drive_reg;
        flow14_next = flow14_reg;
        flow57_next = flow57_reg;
        if (wr_fire) begin
            if (idx == `HDFS_IDX_ENABLE) begin
                enable_next = wbyte[6:0];
            end else if (idx == `HDFS_IDX_SPEED) begin
                speed_next = wbyte[6:0];
            end else if (idx == `HDFS_IDX_DRIVE) begin
                drive_next = wbyte;
            end else if (idx == `HDFS_IDX_FLOW14) begin
                flow14_next = wbyte;
            end else if (idx == `HDFS_IDX_FLOW57) begin
                flow57_next = wbyte[5:0];
            end
        end
        // bus reset disables ports and clears speeds; drive codes survive it
        if (usb_bus_reset) begin
            enable_next = `HDFS_RST_ENABLE;
            speed_next  = `HDFS_RST_SPEED;
        end
    end

    // register reads; unmapped and misaligned addresses read zero
    always_comb begin
        readdata_next = readdata_reg;
        if (rd_load) begin
            readdata_next = 32'h0000_0000;
            if (!word_ok) begin
                readdata_next = 32'h0000_0000;
            end else if (idx == `HDFS_IDX_ENABLE) begin
                readdata_next[6:0] = enable_reg;
            end else if (idx == `HDFS_IDX_SPEED) begin
                readdata_next[6:0] = speed_reg;
            end else if (idx == `HDFS_IDX_DRIVE) begin
                readdata_next[7:0] = drive_reg;
            end else if (idx == `HDFS_IDX_SE0) begin
                readdata_next[6:0] = line.se0;
            end else if (idx == `HDFS_IDX_DATA) begin
                readdata_next[6:0] = line.diff;
            end else if (idx == `HDFS_IDX_FLOW14) begin
                readdata_next[7:0] = flow14_reg;
            end else if (idx == `HDFS_IDX_FLOW57) begin
                readdata_next[5:0] = flow57_reg;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            enable_reg   <= `HDFS_RST_ENABLE;
            speed_reg    <= `HDFS_RST_SPEED;
            drive_reg    <= `HDFS_RST_DRIVE;
            flow14_reg   <= `HDFS_RST_FLOW14;
            flow57_reg   <= `HDFS_RST_FLOW57;
            readdata_reg <= 32'h0000_0000;
            waitreq_reg  <= 1'b1;
        end else begin
            enable_reg   <= enable_next;
            speed_reg    <= speed_next;
            drive_reg    <= drive_next;
            flow14_reg   <= flow14_next;
            flow57_reg   <= flow57_next;
            readdata_reg <= readdata_next;
            waitreq_reg  <= waitreq_next;
        end
    end

    // ports 5 to 7 have no drive field and are never forced by a code
    always_comb begin
        line.drive_code = {6'h00, drive_reg};
        line.low_speed  = speed_reg;
        for (int p = 0; p < `HDFS_NDRIVE; p++) begin
            line.force_dp[p] = flow14_reg[2*p+1];
            line.force_dm[p] = flow14_reg[2*p];
        end
        for (int p = 0; p < `HDFS_NPORTS - `HDFS_NDRIVE; p++) begin
            line.force_dp[p+4] = flow57_reg[2*p+1];
            line.force_dm[p+4] = flow57_reg[2*p];
        end
    end

    hdfs_line_sense u_sense (
        .ref_clk       (ref_clk),
        .resetn        (resetn),
        .usb_bus_reset (usb_bus_reset),
        .dp_in         (dp_in),
        .dm_in         (dm_in),
        .line          (line)
    );

    hdfs_pin_drive u_drive (
        .ref_clk         (ref_clk),
        .resetn          (resetn),
        .line            (line),
        .dp_out          (dp_out),
        .dm_out          (dm_out),
        .dp_oe_n         (dp_oe_n),
        .dm_oe_n         (dm_oe_n),
        .dp_shaped       (dp_shaped),
        .dm_shaped       (dm_shaped),
        .shape_low_speed (shape_low_speed)
    );

    // force-low has no suspend gating, so pins stay low through suspend
    assign avs_readdata    = readdata_reg;
    assign avs_waitrequest = waitreq_reg;
    assign port_enable     = enable_reg;
    assign port_low_speed  = speed_reg;
endmodule

// ### testbench/hdfs_properties.sv
// checker of the downstream port force and sense block
// assumes it is bound to hdfs_top and sees only its ports
`timescale 1ns/1ns
module hdfs_check (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        resetn,
    input wire logic        usb_bus_reset,
    // avalon-mm slave
    input wire logic [9:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // pins and repeater controls
    input wire logic [6:0]  dp_out,
    input wire logic [6:0]  dm_out,
    input wire logic [6:0]  dp_oe_n,
    input wire logic [6:0]  dm_oe_n,
    input wire logic [6:0]  dp_shaped,
    input wire logic [6:0]  dm_shaped,
    input wire logic [6:0]  shape_low_speed,
    input wire logic [6:0]  port_enable,
    input wire logic [6:0]  port_low_speed
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    sequence s_req_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence

    a_req_answered: assert property (s_req_taken |=> !avs_waitrequest)
        else $error("request not answered in one cycle");
    a_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_shaped_driven: assert property (((dp_shaped & dp_oe_n) | (dm_shaped & dm_oe_n)) == 7'h00)
        else $error("shaping on an undriven pin");
    a_no_se1: assert property ((dp_shaped & dm_shaped & dp_out & dm_out) == 7'h00)
        else $error("drive code produced both pins high");
    a_unshaped_low: assert property (((~dp_oe_n & ~dp_shaped & dp_out) | (~dm_oe_n & ~dm_shaped & dm_out)) == 7'h00)
        else $error("unshaped driven pin is not low");
    a_speed_shape: assert property ($changed(port_low_speed) |-> ##[0:1] shape_low_speed == port_low_speed)
        else $error("shaping speed does not follow port speed");
    a_busrst_clears: assert property (usb_bus_reset |-> ##[1:2] (port_enable | port_low_speed) == 7'h00)
        else $error("bus reset left enable or speed set");
    a_reserved_zero: assert property (avs_read && !avs_waitrequest && (avs_address == 10'h13c || avs_address == 10'h140) |-> avs_readdata[31:7] == 25'h000_0000)
        else $error("reserved status bit not zero");
    a_pins_after_write: assert property ($changed(dp_oe_n) || $changed(dm_oe_n) |-> $past(avs_write && !avs_waitrequest) || $past(avs_write && !avs_waitrequest, 2))
        else $error("pin enables changed without a write");
endmodule

bind hdfs_top hdfs_check i_chk (.ref_clk, .resetn, .usb_bus_reset, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .dp_out, .dm_out, .dp_oe_n, .dm_oe_n,
    .dp_shaped, .dm_shaped, .shape_low_speed, .port_enable, .port_low_speed);

// ### testbench/hdfs_usb_dev.sv
// model of the devices on the seven downstream ports
// assumes the bench sets the line level each device drives
`timescale 1ns/1ns
module hdfs_usb_dev (
    // hub pin drive
    input wire logic [6:0] dp_out,
    input wire logic [6:0] dm_out,
    input wire logic [6:0] dp_oe_n,
    input wire logic [6:0] dm_oe_n,
    // device line levels
    input wire logic [6:0] dev_dp,
    input wire logic [6:0] dev_dm,
    // resolved wires
    output logic [6:0]     dp_in,
    output logic [6:0]     dm_in
);
    // the hub driver overpowers the device bias, so its level wins where enabled
    assign dp_in = (dp_out & ~dp_oe_n) | (dev_dp & dp_oe_n);
    assign dm_in = (dm_out & ~dm_oe_n) | (dev_dm & dm_oe_n);
endmodule

// ### testbench/test_hdfs_top.sv
// self-checking bench of the downstream port force and sense block
// assumes hdfs_top, the device model and the bound checker
`timescale 1ns/1ns
module test_hdfs_top;
    logic        ref_clk = 1'b0, resetn = 1'b0, usb_bus_reset = 1'b0;
    logic [9:0]  avs_address = 10'h000;
    logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
    logic [3:0]  avs_byteenable = 4'h0;
    logic [6:0]  dp_in, dm_in, dp_out, dm_out, dp_oe_n, dm_oe_n, dp_shaped, dm_shaped;
    logic [6:0]  shape_low_speed, port_enable, port_low_speed;
    logic [6:0]  dev_dp = 7'h00, dev_dm = 7'h7f;
    logic [7:0]  ridx[8] = '{8'h49, 8'h4a, 8'h4b, 8'h4f, 8'h50, 8'h51, 8'h52, 8'h60};
    int          miscompares = 0, n_compared = 0, cycles = 0;

    always #2 ref_clk = ~ref_clk;

    hdfs_top i_dut (.ref_clk, .resetn, .usb_bus_reset, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .dp_in, .dm_in,
        .dp_out, .dm_out, .dp_oe_n, .dm_oe_n, .dp_shaped, .dm_shaped, .shape_low_speed,
        .port_enable, .port_low_speed);
    hdfs_usb_dev i_dev (.dp_out, .dm_out, .dp_oe_n, .dm_oe_n, .dev_dp, .dev_dm, .dp_in, .dm_in);

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        avs_write <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic rdc(input string what, input logic [7:0] idx, input logic [7:0] exp);
        @(posedge ref_clk);
        avs_address <= {idx, 2'b00};
        avs_read <= 1'b1;
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        chk(what, exp, avs_readdata[7:0]);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    // device lines move on a clock edge; six cycles covers the sync and update
    task automatic dev(input logic [6:0] dp, input logic [6:0] dm);
        @(posedge ref_clk);
        dev_dp <= dp;
        dev_dm <= dm;
        cyc(6);
    endtask

    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            complete_run();
        end
    end

    initial begin
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        foreach (ridx[i]) rdc("reset value", ridx[i], 8'h00);
        $display("test reset done");
        // ports stay disabled while forced
        wr(8'h49, 8'h00, 4'hf);
        wr(8'h4a, 8'h55, 4'hf);
        cyc(2);
        chk("shape speed", 8'h55, {1'b0, shape_low_speed});
        for (int p = 0; p < 4; p++) begin
            for (int c = 0; c < 4; c++) begin
                wr(8'h4b, 8'(c << (2 * p)), 4'h1);
                cyc(2);
                chk("drive pins", {3'b000, c == 0, c == 0, c != 0, c == 1, c == 2}, {3'b000, dp_oe_n[p], dm_oe_n[p], dp_shaped[p], c != 0 && dp_out[p], c != 0 && dm_out[p]});
            end
        end
        $display("test drive codes done");
        wr(8'h4b, 8'h03, 4'h1);
        wr(8'h51, 8'h02, 4'h1);
        cyc(2);
        chk("force vs drive", 8'h02, {2'b00, dp_oe_n[0], dp_shaped[0], dp_out[0], dm_oe_n[0], dm_shaped[0], dm_out[0]});
        wr(8'h4b, 8'h00, 4'h1);
        wr(8'h51, 8'hff, 4'h1);
        wr(8'h52, 8'hff, 4'h1);
        rdc("force 5-7", 8'h52, 8'h3f);
        cyc(2);
        chk("all low", 8'h00, {1'b0, dp_oe_n | dm_oe_n | dp_shaped | dm_shaped | dp_out | dm_out});
        cyc(6);
        rdc("se0 forced", 8'h4f, 8'h7f);
        wr(8'h51, 8'h00, 4'h1);
        wr(8'h52, 8'h00, 4'h1);
        $display("test force low done");
        dev(7'h7f, 7'h00);
        rdc("data j", 8'h50, 8'h7f);
        rdc("se0 none", 8'h4f, 8'h00);
        dev(7'h55, 7'h2a);
        rdc("data mixed", 8'h50, 8'h55);
        wr(8'h4a, 8'h00, 4'h1);
        dev(7'h50, 7'h28);
        rdc("data held", 8'h50, 8'h55);
        rdc("se0 ports", 8'h4f, 8'h07);
        $display("test sensing done");
        dev(7'h7f, 7'h00);
        dev(7'h00, 7'h00);
        wr(8'h4b, 8'hc0, 4'h1);
        wr(8'h49, 8'h70, 4'h1);
        wr(8'h4a, 8'h11, 4'h1);
        cyc(1);
        chk("enable pins", 8'h70, {1'b0, port_enable});
        chk("speed pins", 8'h11, {1'b0, port_low_speed});
        @(posedge ref_clk);
        usb_bus_reset <= 1'b1;
        @(posedge ref_clk);
        usb_bus_reset <= 1'b0;
        cyc(2);
        chk("bus reset ctl", 8'h00, {1'b0, port_enable | port_low_speed});
        rdc("data cleared", 8'h50, 8'h00);
        rdc("drive kept", 8'h4b, 8'hc0);
        wr(8'h4b, 8'h55, 4'h0);
        rdc("masked write", 8'h4b, 8'hc0);
        wr(8'h4b, 8'h00, 4'h1);
        $display("test bus reset done");
        complete_run();
    end
endmodule
